// [hdl/cmbi_bus_interface.sv]
// Processor-side multiplexed address/data bus interface
// What this block does
// - One 32-bit bus carries address first, then data of the same transfer.
// - Address phase drives upper address bits and the four byte strobes.
// - Active-low byte strobes each pick one byte lane, 3 is the top byte.
// - Writes drive store data from write buffer; reads load the read buffer.
// - Low word address gives word address; bursts count up from zero.
// - Address latch strobe is high while the bus holds the address.
// - Data input enable low only in reads after the bus is released.
// - Burst only on miss reads: all instruction, data if strapped at reset.
// - On writes the burst pin flags a back-to-back write in the same page.
// - Separate read and write strobes mark the transfer kind.
// - Acknowledge advances the write buffer or releases read data to core.
// - Read buffer load enable loads the bus word into the read buffer.
// - Transfer fault ends a read or write; on reads it raises an exception.
// - Diagnostic 1 in address phase is high for a cache-miss read.
// - Diagnostic 1 later in reads shows address bit 3; it stays low in write data.
// - Diagnostic 0 in address phase: high instruction, low data miss.
// - Diagnostic 0 later in reads shows address bit 2; it stays low in write data.
// - Master request floats bus outputs except diag; its release returns the bus.
// - A four-entry read buffer queues burst words at any pacing.
// - Single read takes more than two cycles even without waits: answers pass the synchroniser and filter first.
// - Writes take two cycles or more with any number of waits.
// - Burst pin low asks four words, high asks one.
// - Load enable seen at rising edge captures data at next falling edge.
// - Grant output tells the external master the bus is released.
`include "cmbi_cfg.svh"
`default_nettype none
module cmbi_bus_interface (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Strap sampled at reset release
    input wire logic dataBurstStrap,
    // Core request side
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [31:0] reqAddr,
    input wire logic [3:0] reqByteEn,
    input wire logic [31:0] reqWData,
    input wire logic reqMiss,
    input wire logic reqInstr,
    output logic reqReady,
    // Core answer side
    output logic rspValid,
    output logic [31:0] rspData,
    output logic [1:0] rspWord,
    output logic rspFault,
    output logic writeRetired,
    // Multiplexed bus
    input wire logic [31:0] adIn,
    output logic [31:0] adOut,
    output logic adOe,
    output logic [1:0] wordAddr,
    output logic wordAddrOe,
    output logic addrLatch,
    output logic data_input_enable_n,
    output logic burstNearN,
    output logic readN,
    output logic writeN,
    output logic ctrlOe,
    output logic [3:0] diag,
    // Memory answers, active low
    input wire logic ackN,
    input wire logic read_buffer_load_enable_n,
    input wire logic transfer_fault_in_n,
    // Arbitration
    input wire logic master_request_in_n,
    output logic master_grant_out_n
);
    import cmbi_pkg::*;

    cmbi_state_t state, next_state;
    logic [31:0] addr, next_addr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] be, next_be;
    logic isWrite, next_isWrite;
    logic burst, next_burst;
    logic miss, next_miss;
    logic instr, next_instr;
    logic near, next_near;
    logic [1:0] cnt, next_cnt;
    logic [`CMBI_PAGE_W-1:0] lastPage, next_lastPage;
    logic lastWasWrite, next_lastWasWrite;
    logic acked, next_acked;
    logic dataBurst;
    logic strapTaken;
    logic [31:0] rbuf [`CMBI_BURST_WORDS];
    logic [1:0] rbufWr, rbufRd, next_rbufRd;
    logic [2:0] rbufCnt, next_rbufCnt;
    logic [31:0] adSample;
    logic loadFall;
    logic [1:0] loadIdx;
    logic [2:0] loadCount;
    logic [3:0] inSync;
    logic ackS, loadS, faultS, reqS;
    logic next_rspValid, next_rspFault, next_writeRetired;
    logic [31:0] next_rspData;
    logic [1:0] next_rspWord;

    cmbi_sync #(.W(4)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async({~ackN, ~read_buffer_load_enable_n, ~transfer_fault_in_n,
                ~master_request_in_n}),
        .synced(inSync)
    );
    assign {ackS, loadS, faultS, reqS} = inSync;

    function automatic logic [`CMBI_PAGE_W-1:0] pageOf(input logic [31:0] a);
        return a[`CMBI_PAGE_LSB +: `CMBI_PAGE_W];
    endfunction : pageOf

    // Strap caught by a clocked process after release, not by the reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            strapTaken <= 1'b0;
            dataBurst <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken <= 1'b1;
            dataBurst <= dataBurstStrap;
        end
    end

    // Data captured on the falling edge after load enable was seen
    always_ff @(negedge clock or negedge nrst) begin
        if (!nrst) begin
            adSample <= '0;
            loadFall <= 1'b0;
            loadIdx <= 2'h0;
            loadCount <= 3'h0;
        end else begin
            // One word per filtered assertion: the filter passes a pulse of two cycles
            // or more at its full length, so counting a held level would overrun
            loadFall <= loadS;
            if ((state == CMBI_RDATA) && loadS && !loadFall && !acked) begin
                adSample <= adIn;
                loadIdx <= cnt;
                loadCount <= loadCount + 3'h1;
            end
        end
    end

    // Falling-edge strobe moved into the rising domain for the buffer write
    logic loadPrev;
    logic [2:0] loadSeen;
    assign loadPrev = (loadCount != loadSeen);

    always_comb begin
        next_state = state;
        next_addr = addr;
        next_wdata = wdata;
        next_be = be;
        next_isWrite = isWrite;
        next_burst = burst;
        next_miss = miss;
        next_instr = instr;
        next_near = near;
        next_cnt = cnt;
        next_lastPage = lastPage;
        next_lastWasWrite = lastWasWrite;
        next_acked = acked;
        next_rbufRd = rbufRd;
        next_rbufCnt = rbufCnt;
        next_rspValid = 1'b0;
        next_rspFault = 1'b0;
        next_writeRetired = 1'b0;
        next_rspData = rspData;
        next_rspWord = rspWord;
        // Answers of the last transfer must have left the filter first
        reqReady = (state == CMBI_IDLE) && !reqS && strapTaken && !ackS && !loadS && !faultS;
        case (state)
            CMBI_IDLE: begin
                if (reqS) begin
                    next_state = CMBI_HELD;
                end else if (reqValid && reqReady) begin
                    next_state = CMBI_ADDR;
                    next_addr = reqAddr;
                    next_be = reqByteEn;
                    next_wdata = reqWData;
                    next_isWrite = reqWrite;
                    next_miss = reqMiss && !reqWrite;
                    next_instr = reqInstr;
                    next_burst = !reqWrite && reqMiss && (reqInstr || dataBurst);
                    next_near = reqWrite && lastWasWrite
                        && (pageOf(reqAddr) == lastPage);
                    next_cnt = (!reqWrite && reqMiss && (reqInstr || dataBurst))
                        ? `CMBI_WORD_RST : reqAddr[3:2];
                    next_acked = 1'b0;
                    next_rbufCnt = 3'h0;
                    next_rbufRd = 2'h0;
                    next_lastWasWrite = reqWrite;
                    if (reqWrite) begin
                        next_lastPage = pageOf(reqAddr);
                    end
                end
            end
            CMBI_ADDR: begin
                next_state = isWrite ? CMBI_WDATA : CMBI_RDATA;
            end
            CMBI_WDATA: begin
                if (faultS || ackS) begin
                    next_state = CMBI_IDLE;
                    next_writeRetired = 1'b1;
                end
            end
            CMBI_RDATA: begin
                if (loadPrev) begin
                    // Single reads keep the word address steady
                    if (burst) begin
                        next_cnt = cnt + 2'h1;
                    end
                    next_rbufCnt = rbufCnt + 3'h1;
                end
                if (ackS) begin
                    next_acked = 1'b1;
                end
                if (faultS) begin
                    next_state = CMBI_IDLE;
                    next_rspValid = 1'b1;
                    next_rspFault = 1'b1;
                end else if ((acked || ackS) && (rbufCnt != 3'h0)) begin
                    // Core drains the buffer one word a cycle once acknowledged
                    next_rspValid = 1'b1;
                    next_rspData = rbuf[rbufRd];
                    next_rspWord = burst ? rbufRd : addr[3:2];
                    next_rbufRd = rbufRd + 2'h1;
                    next_rbufCnt = next_rbufCnt - 3'h1;
                    if (!burst || (rbufRd == 2'h3)) begin
                        next_state = CMBI_IDLE;
                    end
                end
            end
            CMBI_HELD: begin
                if (!reqS) begin
                    next_state = CMBI_IDLE;
                end
            end
            default: begin
                next_state = CMBI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= CMBI_IDLE;
            addr <= '0;
            wdata <= '0;
            be <= `CMBI_BE_IDLE;
            isWrite <= 1'b0;
            burst <= 1'b0;
            miss <= 1'b0;
            instr <= 1'b0;
            near <= 1'b0;
            cnt <= `CMBI_WORD_RST;
            lastPage <= '0;
            lastWasWrite <= 1'b0;
            acked <= 1'b0;
            rbufRd <= 2'h0;
            rbufCnt <= 3'h0;
            rspValid <= 1'b0;
            rspFault <= 1'b0;
            writeRetired <= 1'b0;
            rspData <= '0;
            rspWord <= 2'h0;
            loadSeen <= 3'h0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            wdata <= next_wdata;
            be <= next_be;
            isWrite <= next_isWrite;
            burst <= next_burst;
            miss <= next_miss;
            instr <= next_instr;
            near <= next_near;
            cnt <= next_cnt;
            lastPage <= next_lastPage;
            lastWasWrite <= next_lastWasWrite;
            acked <= next_acked;
            rbufRd <= next_rbufRd;
            rbufCnt <= next_rbufCnt;
            rspValid <= next_rspValid;
            rspFault <= next_rspFault;
            writeRetired <= next_writeRetired;
            rspData <= next_rspData;
            rspWord <= next_rspWord;
            loadSeen <= loadCount;
        end
    end

    // Read buffer, written in order of word count
    always_ff @(posedge clock) begin
        if (loadPrev && (state == CMBI_RDATA)) begin
            rbuf[rbufWr] <= adSample;
        end
    end
    assign rbufWr = burst ? loadIdx : 2'h0;

    // Bus pins; address/data, word address and control float while the external master owns the bus, diag stays driven
    always_comb begin
        adOut = '0;
        adOe = 1'b0;
        diag = 4'h0;
        diag[3:2] = 2'h0;
        if (state == CMBI_ADDR) begin
            adOut = {addr[31:4], be};
            adOe = 1'b1;
            diag[1] = miss;
            diag[0] = miss & instr;
        end else if (state == CMBI_WDATA) begin
            adOut = wdata;
            adOe = 1'b1;
        end else if (state == CMBI_RDATA) begin
            diag[1] = addr[3];
            diag[0] = addr[2];
        end
    end
    assign wordAddr = cnt;
    assign addrLatch = (state == CMBI_ADDR);
    assign data_input_enable_n = !(state == CMBI_RDATA);
    assign burstNearN = isWrite ? !near : !burst;
    assign readN = !((state != CMBI_IDLE) && (state != CMBI_HELD) && !isWrite);
    assign writeN = !((state != CMBI_IDLE) && (state != CMBI_HELD) && isWrite);
    assign ctrlOe = (state != CMBI_HELD);
    assign wordAddrOe = ctrlOe;
    assign master_grant_out_n = !(state == CMBI_HELD);
endmodule : cmbi_bus_interface
`default_nettype wire

// [hdl/cmbi_cfg.svh]
// Constants of the multiplexed processor bus interface
`ifndef CMBI_CFG_SVH
`define CMBI_CFG_SVH
`define CMBI_DATA_W 32
`define CMBI_BURST_WORDS 4
`define CMBI_PAGE_ENTRIES 256
`define CMBI_PAGE_LSB 4
`define CMBI_PAGE_W 8
`define CMBI_WORD_RST 2'h0
`define CMBI_BE_IDLE 4'hf
`endif

// [hdl/cmbi_pkg.sv]
// Types of the multiplexed processor bus interface
`default_nettype none
package cmbi_pkg;
    typedef enum logic [2:0] {
        CMBI_IDLE = 3'h0,
        CMBI_ADDR = 3'h1,
        CMBI_RDATA = 3'h2,
        CMBI_WDATA = 3'h3,
        CMBI_HELD = 3'h4
    } cmbi_state_t;
endpackage : cmbi_pkg
`default_nettype wire

// [hdl/cmbi_sync.sv]
// Three-flop input synchroniser with agreement filter
`default_nettype none
module cmbi_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_synced;
    always_comb begin
        next_synced = synced;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_synced[i] = s3[i];
            end
        end
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            synced <= '0;
        end else begin
            s1 <= async;
            s2 <= s1;
            s3 <= s2;
            synced <= next_synced;
        end
    end
endmodule : cmbi_sync
`default_nettype wire

// [verif/cmbi_bus_interface_asserts.sv]
// Pin-level checker of the multiplexed bus interface
`default_nettype none
module cmbi_bus_interface_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Core side
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [31:0] reqAddr,
    input wire logic [3:0] reqByteEn,
    input wire logic [31:0] reqWData,
    input wire logic reqMiss,
    input wire logic reqInstr,
    // Bus side
    input wire logic [31:0] adOut,
    input wire logic adOe,
    input wire logic [1:0] wordAddr,
    input wire logic addrLatch,
    input wire logic data_input_enable_n,
    input wire logic burstNearN,
    input wire logic readN,
    input wire logic writeN,
    input wire logic ctrlOe,
    input wire logic [3:0] diag,
    input wire logic master_grant_out_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Request as taken, the core may change its lines afterwards
    logic [31:0] tAddr;
    logic [31:0] tData;
    logic [3:0] tBe;
    logic tMiss;
    logic tInstr;
    always_ff @(posedge clock) begin
        if (reqValid && reqReady) begin
            {tAddr, tData, tBe, tMiss, tInstr} <=
                {reqAddr, reqWData, reqByteEn, reqMiss, reqInstr};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_latch_pulse: assert property (addrLatch |=> !addrLatch)
        else $error("address latch held too long");
    a_addr_phase: assert property (addrLatch
        |-> adOe && adOut == {tAddr[31:4], tBe})
        else $error("address phase content wrong");
    a_write_data: assert property (!writeN && !addrLatch |-> adOe && adOut == tData)
        else $error("write data not on bus");
    a_enable_idle: assert property (!writeN || readN |-> data_input_enable_n)
        else $error("data enable outside read");
    a_enable_free: assert property (!data_input_enable_n |-> !adOe && !addrLatch)
        else $error("data enable while driving");
    a_kind_apart: assert property (readN || writeN)
        else $error("read and write together");
    a_burst_miss: assert property (addrLatch && !readN && !burstNearN
        |-> tMiss && wordAddr == 2'h0)
        else $error("burst not from miss or not at word zero");
    a_burst_instr: assert property (addrLatch && !readN && tMiss && tInstr
        |-> !burstNearN)
        else $error("instruction miss without burst");
    a_single_word: assert property (addrLatch && (!writeN || burstNearN)
        |-> wordAddr == tAddr[3:2])
        else $error("word address wrong");
    a_diag_phase: assert property (addrLatch && !readN
        |-> diag[1] == tMiss && (!tMiss || diag[0] == tInstr))
        else $error("diagnostic wrong in address phase");
    a_diag_addr: assert property (!readN && !addrLatch
        |-> diag[1:0] == tAddr[3:2])
        else $error("diagnostic address bits wrong");
    a_grant_float: assert property (!master_grant_out_n |-> !adOe && !ctrlOe)
        else $error("outputs driven while granted");
    a_count_step: assert property (!readN && !$past(readN) && $changed(wordAddr)
        |-> wordAddr == $past(wordAddr) + 2'h1)
        else $error("word counter skipped");
    a_single_hold: assert property (!readN && burstNearN && !$past(readN)
        |-> $stable(wordAddr))
        else $error("word address moved in single read");
endmodule : cmbi_bus_interface_asserts
bind cmbi_bus_interface cmbi_bus_interface_asserts i_cmbi_bus_interface_asserts (
    .clock(clock), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
    .reqByteEn(reqByteEn), .reqWData(reqWData), .reqMiss(reqMiss), .reqInstr(reqInstr),
    .adOut(adOut), .adOe(adOe), .wordAddr(wordAddr), .addrLatch(addrLatch),
    .data_input_enable_n(data_input_enable_n), .burstNearN(burstNearN), .readN(readN),
    .writeN(writeN), .ctrlOe(ctrlOe), .diag(diag), .master_grant_out_n(master_grant_out_n));
`default_nettype wire

// [verif/cmbi_mem_model.sv]
// Behavioural memory controller on the far side of the bus
`default_nettype none
module cmbi_mem_model (
    // Clock and pacing
    input wire logic clock,
    input wire logic [3:0] waits,
    input wire logic faultOn,
    // Device pins
    input wire logic [31:0] adOut,
    input wire logic [1:0] wordAddr,
    input wire logic addrLatch,
    input wire logic data_input_enable_n,
    input wire logic burstNearN,
    input wire logic readN,
    input wire logic writeN,
    // Memory answers
    output logic [31:0] adIn,
    output logic ackN,
    output logic read_buffer_load_enable_n,
    output logic transfer_fault_in_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] capAddr;
    logic [31:0] capData;
    logic [31:0] drv;
    logic [1:0] capWord;
    logic [1:0] w;
    logic capBurst;
    int n;
    int k;
    // Undriven bus shows the inverse, so stale data never matches
    assign adIn = data_input_enable_n ? ~drv : drv;
    initial begin
        {drv, ackN, read_buffer_load_enable_n, transfer_fault_in_n} = {32'h0, 3'h7};
        forever begin
            @(posedge clock);
            if (addrLatch === 1'b1) begin
                {capAddr, capWord, capBurst} = {adOut, wordAddr, burstNearN};
                n = (burstNearN === 1'b0 && readN === 1'b0) ? 4 : 1;
                if (writeN === 1'b0) begin
                    @(posedge clock);
                    capData = adOut;
                end
                repeat (waits) @(posedge clock);
                if (faultOn) transfer_fault_in_n <= 1'b0;
                else if (writeN === 1'b0) ackN <= 1'b0;
                else begin
                    for (int i = 0; i < n; i++) begin
                        w = wordAddr;
                        drv <= {capAddr[31:4], i[1:0], 2'h0} ^ 32'h5a5a5a5a;
                        read_buffer_load_enable_n <= 1'b0;
                        if (n == 1) ackN <= 1'b0;
                        if (n > 1) begin
                            for (k = 0; k < 40 && wordAddr === w; k++) @(posedge clock);
                            read_buffer_load_enable_n <= 1'b1;
                            drv <= ~drv;
                            // Gap long enough for the filtered input to see it
                            repeat (waits + 4) @(posedge clock);
                        end
                    end
                    if (n > 1) ackN <= 1'b0;
                end
                for (k = 0; k < 80 && !(readN === 1'b1 && writeN === 1'b1); k++) @(posedge clock);
                {ackN, read_buffer_load_enable_n, transfer_fault_in_n} <= 3'h7;
                drv <= ~drv;
            end
        end
    end
endmodule : cmbi_mem_model
`default_nettype wire

// [verif/test_cmbi_bus_interface.sv]
// Self-checking bench of the multiplexed bus interface
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failCount++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module test_cmbi_bus_interface;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, nrst, dataBurstStrap, reqValid, reqWrite, reqMiss, reqInstr, reqReady;
    logic rspValid, rspFault, writeRetired, adOe, wordAddrOe, addrLatch, ctrlOe, faultOn;
    logic data_input_enable_n, burstNearN, readN, writeN, ackN, loadN, faultN;
    logic master_request_in_n, master_grant_out_n;
    logic [31:0] reqAddr, reqWData, rspData, adIn, adOut;
    logic [3:0] reqByteEn, diag, waits;
    logic [1:0] rspWord, wordAddr;
    logic [31:0] gotData[$];
    logic [1:0] gotWord[$];
    int failCount, compares, retired, faults;
    cmbi_bus_interface i_cmbi_bus_interface (.clock(clock), .nrst(nrst),
        .dataBurstStrap(dataBurstStrap), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqByteEn(reqByteEn), .reqWData(reqWData), .reqMiss(reqMiss),
        .reqInstr(reqInstr), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
        .rspWord(rspWord), .rspFault(rspFault), .writeRetired(writeRetired), .adIn(adIn),
        .adOut(adOut), .adOe(adOe), .wordAddr(wordAddr), .wordAddrOe(wordAddrOe),
        .addrLatch(addrLatch), .data_input_enable_n(data_input_enable_n),
        .burstNearN(burstNearN), .readN(readN), .writeN(writeN), .ctrlOe(ctrlOe), .diag(diag),
        .ackN(ackN), .read_buffer_load_enable_n(loadN), .transfer_fault_in_n(faultN),
        .master_request_in_n(master_request_in_n), .master_grant_out_n(master_grant_out_n));
    cmbi_mem_model i_cmbi_mem_model (.clock(clock), .waits(waits), .faultOn(faultOn),
        .adOut(adOut), .wordAddr(wordAddr), .addrLatch(addrLatch),
        .data_input_enable_n(data_input_enable_n), .burstNearN(burstNearN), .readN(readN),
        .writeN(writeN), .adIn(adIn), .ackN(ackN), .read_buffer_load_enable_n(loadN),
        .transfer_fault_in_n(faultN));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rspValid === 1'b1) gotData.push_back(rspData);
        if (rspValid === 1'b1) gotWord.push_back(rspWord);
        if (writeRetired === 1'b1) retired++;
        if (rspFault === 1'b1) faults++;
    end
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failCount);
        if (failCount == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic doReset(input logic strap);
        nrst <= 1'b0;
        dataBurstStrap <= strap;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : doReset
    task automatic req(input logic wr, input logic [31:0] a, input logic [3:0] be,
        input logic miss, input logic instr);
        int k;
        reqValid <= 1'b1;
        {reqWrite, reqAddr, reqByteEn, reqWData, reqMiss, reqInstr} <= {wr, a, be, ~a, miss, instr};
        k = 0;
        do begin @(posedge clock); k++; end while (reqReady !== 1'b1 && k < 200);
        reqValid <= 1'b0;
    endtask : req
    task automatic wrTest(input logic [31:0] a, input logic [3:0] be, input logic near);
        int r = retired;
        req(1'b1, a, be, 1'b0, 1'b0);
        for (int k = 0; k < 200 && retired == r; k++) @(posedge clock);
        `CHK(retired, r + 1)
        `CHK(i_cmbi_mem_model.capAddr, {a[31:4], be})
        `CHK(i_cmbi_mem_model.capData, ~a)
        `CHK(i_cmbi_mem_model.capWord, a[3:2])
        `CHK(i_cmbi_mem_model.capBurst, near)
        $display("write test done");
    endtask : wrTest
    task automatic rdTest(input logic [31:0] a, input logic miss, input logic instr, input int n);
        gotData.delete();
        gotWord.delete();
        req(1'b0, a, 4'h0, miss, instr);
        for (int k = 0; k < 400 && gotData.size() < n; k++) @(posedge clock);
        `CHK(gotData.size(), n)
        `CHK(i_cmbi_mem_model.capBurst, logic'(n == 1))
        `CHK(i_cmbi_mem_model.capWord, (n == 4) ? 2'h0 : a[3:2])
        for (int i = 0; i < n; i++) begin
            `CHK(gotData[i], {a[31:4], i[1:0], 2'h0} ^ 32'h5a5a5a5a)
            `CHK(gotWord[i], (n == 4) ? i[1:0] : a[3:2])
        end
        $display("read test done");
    endtask : rdTest
    task automatic errTest();
        int r = retired;
        int f = faults;
        faultOn <= 1'b1;
        req(1'b1, 32'h00007770, 4'h0, 1'b0, 1'b0);
        for (int k = 0; k < 200 && retired == r; k++) @(posedge clock);
        req(1'b0, 32'h00007774, 4'h0, 1'b0, 1'b0);
        for (int k = 0; k < 200 && faults == f; k++) @(posedge clock);
        `CHK(retired, r + 1)
        `CHK(faults, f + 1)
        faultOn <= 1'b0;
        $display("fault test done");
    endtask : errTest
    task automatic grantTest();
        master_request_in_n <= 1'b0;
        for (int k = 0; k < 40 && master_grant_out_n !== 1'b0; k++) @(posedge clock);
        @(posedge clock);
        `CHK({master_grant_out_n, adOe, ctrlOe, wordAddrOe, reqReady}, 5'h0)
        master_request_in_n <= 1'b1;
        for (int k = 0; k < 40 && master_grant_out_n !== 1'b1; k++) @(posedge clock);
        @(posedge clock);
        `CHK({master_grant_out_n, wordAddrOe, reqReady}, 3'h7)
        $display("grant test done");
    endtask : grantTest
    initial begin
        {nrst, dataBurstStrap, reqValid, reqWrite, reqMiss, reqInstr, faultOn} = 7'h0;
        {reqAddr, reqWData, reqByteEn, waits, master_request_in_n} = {72'h0, 1'b1};
        doReset(1'b0);
        wrTest(32'h00001234, 4'h0, 1'b1);
        wrTest(32'h00001238, 4'hc, 1'b0);
        wrTest(32'h00001334, 4'h3, 1'b1);
        waits <= 4'h3;
        rdTest(32'h00004568, 1'b0, 1'b0, 1);
        rdTest(32'h000089a4, 1'b1, 1'b1, 4);
        rdTest(32'h0000bcd8, 1'b1, 1'b0, 1);
        waits <= 4'h0;
        rdTest(32'h0000cdec, 1'b1, 1'b1, 4);
        errTest();
        grantTest();
        doReset(1'b1);
        rdTest(32'h0000def4, 1'b1, 1'b0, 4);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        failCount++;
        conclude();
    end
endmodule : test_cmbi_bus_interface
`default_nettype wire
